// [design/ser_pkg.sv]
// Constants and types shared by the status event reporting block.
`default_nettype none
package ser_pkg;
  localparam int unsigned STB_W = 8;
  localparam int unsigned ESR_W = 8;
  localparam int unsigned LIA_W = 15;
  localparam int unsigned ERR_W = 8;
  localparam int unsigned IDX_W = 4;
  // Serial poll status byte positions.
  localparam int unsigned STB_ERR_BIT = 2;
  localparam int unsigned STB_LIA_BIT = 3;
  localparam int unsigned STB_MAV_BIT = 4;
  localparam int unsigned STB_ESB_BIT = 5;
  localparam int unsigned STB_RQS_BIT = 6;
  // Standard event byte positions.
  localparam int unsigned ESR_OPC_BIT = 0;
  localparam int unsigned ESR_INP_BIT = 1;
  localparam int unsigned ESR_QRY_BIT = 3;
  localparam int unsigned ESR_EXE_BIT = 4;
  localparam int unsigned ESR_CMD_BIT = 5;
  localparam int unsigned ESR_URQ_BIT = 6;
  localparam int unsigned ESR_PON_BIT = 7;
  // Lock-in status word positions.
  localparam int unsigned LIA_REFERENCE_UNLOCK_BIT = 3;
  localparam int unsigned LIA_RANGE_BIT = 4;
  localparam int unsigned LIA_DAT1_BIT = 8;
  // Error byte positions.
  localparam int unsigned ERR_CLK_BIT = 0;
  localparam int unsigned ERR_VXI_BIT = 4;
  // Implemented bits; the others read as zero.
  localparam logic [ESR_W-1:0] ESR_USED = 8'hFB;
  localparam logic [LIA_W-1:0] LIA_USED = 15'h7FFB;
  localparam logic [ERR_W-1:0] ERR_USED = 8'hF3;
  // Values after reset.
  localparam logic [ESR_W-1:0] ESR_RESET = 8'h00;
  localparam logic [LIA_W-1:0] LIA_RESET = 15'h0000;
  localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
  localparam logic [STB_W-1:0] STB_RESET = 8'h00;
  typedef enum logic [3:0] {
    SER_Q_SPOLL = 4'b0001,
    SER_Q_STD = 4'b0010,
    SER_Q_LOCKIN = 4'b0100,
    SER_Q_ERROR = 4'b1000
  } ser_query_e;
endpackage
`default_nettype wire

// [design/ser_if.sv]
// Interfaces joining the top to the status stores and the request generator.
`default_nettype none
interface ser_stat_if #(parameter int unsigned W = 8);
  logic [W-1:0] set;
  logic [W-1:0] rd_clr;
  logic [W-1:0] enable;
  logic [W-1:0] status;
  logic clr_all;
  logic summary;
  modport ctl (output set, rd_clr, enable, clr_all, input status, summary);
  modport store (input set, rd_clr, enable, clr_all, output status, summary);
endinterface

interface ser_srq_if;
  logic [7:0] cond;
  logic [7:0] enable;
  logic poll;
  logic pending;
  logic mss;
  modport ctl (output cond, enable, poll, input pending, mss);
  modport gen (input cond, enable, poll, output pending, mss);
endinterface
`default_nettype wire

// [design/ser_sticky.sv]
// Sticky status register with read clear, clear-all and enabled summary.
`default_nettype none
module ser_sticky #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] USED = '1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  ser_stat_if.store st
);
  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic [W-1:0] keep_mask;

  assign keep_mask = ~(st.rd_clr | {W{st.clr_all}});
  // A new event wins over a clear in the same cycle.
  assign status_next = (status_reg & keep_mask) | (st.set & USED);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      status_reg <= RESET_VAL;
    else
      status_reg <= status_next;
  end

  assign st.status = status_reg;
  assign st.summary = |(status_reg & st.enable);
endmodule // ser_sticky
`default_nettype wire

// [design/ser_srq.sv]
// Service request generator: edge detect on enabled poll bits, cleared by poll.
`default_nettype none
module ser_srq (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  ser_srq_if.gen sq
);
  import ser_pkg::*;
  logic [7:0] en_bits;
  logic [7:0] prev_reg;
  logic rise;
  logic pending_reg;
  logic pending_next;

  assign en_bits = sq.cond & sq.enable & ~(8'h01 << STB_RQS_BIT);
  assign rise = |(en_bits & ~prev_reg);
  assign pending_next = rise | (pending_reg & ~sq.poll);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_reg <= STB_RESET;
      pending_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= en_bits;
      pending_reg <= pending_next;
    end
  end

  assign sq.pending = pending_reg;
  assign sq.mss = |en_bits;
endmodule // ser_srq
`default_nettype wire

// [design/ser_top.sv]
// Status event reporting: three sticky status stores, poll byte and service request.
`default_nettype none
module ser_top (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic evt_opc_i,
  input wire logic in_queue_overflow_i,
  input wire logic out_queue_overflow_i,
  input wire logic evt_exec_err_i,
  input wire logic evt_illegal_cmd_i,
  input wire logic evt_front_panel_i,
  input wire logic out1_scale_overload_i,
  input wire logic out2_scale_overload_i,
  input wire logic reference_unlock_i,
  input wire logic input_range_overload_i,
  input wire logic sync_freq_out_of_range_i,
  input wire logic sync_filter_overload_i,
  input wire logic storage_triggered_i,
  input wire logic data_ch1_overload_i,
  input wire logic data_ch2_overload_i,
  input wire logic data_ch3_overload_i,
  input wire logic data_ch4_overload_i,
  input wire logic capture_done_i,
  input wire logic sweep_started_i,
  input wire logic sweep_done_i,
  input wire logic ext_ref_clock_err_i,
  input wire logic battery_backup_fail_i,
  input wire logic vxi_err_i,
  input wire logic gpib_fast_abort_i,
  input wire logic usb_device_fault_i,
  input wire logic usb_host_fault_i,
  input wire logic out_buf_nonempty_i,
  input wire logic [ser_pkg::ESR_W-1:0] std_enable_i,
  input wire logic [ser_pkg::LIA_W-1:0] lockin_enable_i,
  input wire logic [ser_pkg::ERR_W-1:0] error_enable_i,
  input wire logic [ser_pkg::STB_W-1:0] spoll_enable_i,
  input wire logic clear_all_i,
  input wire logic query_valid_i,
  input wire ser_pkg::ser_query_e query_target_i,
  input wire logic query_one_bit_i,
  input wire logic [ser_pkg::IDX_W-1:0] query_bit_idx_i,
  input wire logic serial_poll_i,
  output logic [ser_pkg::LIA_W-1:0] query_data_o,
  output logic query_done_o,
  output logic [ser_pkg::STB_W-1:0] spoll_byte_o,
  output logic spoll_done_o,
  output logic srq_o,
  output logic queue_flush_o
);
  import ser_pkg::*;

  // Clear mask for a read: all bits, or only the selected bit.
  function automatic logic [15:0] rd_mask(input logic hit);
    logic [15:0] m;
    m = query_one_bit_i ? (16'h0001 << query_bit_idx_i) : 16'hFFFF;
    return hit ? m : 16'h0000;
  endfunction

  // Answer for a read: the whole value or the selected bit in bit 0.
  function automatic logic [14:0] pick(input logic [15:0] v);
    logic [14:0] r;
    r = query_one_bit_i ? {14'h0000, v[query_bit_idx_i]} : v[14:0];
    return r;
  endfunction

  ser_stat_if #(.W(ESR_W)) std_if ();
  ser_stat_if #(.W(LIA_W)) lia_if ();
  ser_stat_if #(.W(ERR_W)) err_if ();
  ser_srq_if srq_if ();

  logic pon_pending_reg;
  logic queue_flush_reg;
  logic [LIA_W-1:0] query_data_reg;
  logic [LIA_W-1:0] query_data_next;
  logic query_done_reg;
  logic [STB_W-1:0] spoll_byte_reg;
  logic spoll_done_reg;
  logic overflow;
  logic [STB_W-1:0] stb_cond;
  logic [STB_W-1:0] stb_read;
  logic [STB_W-1:0] spoll_en;
  logic hit_spoll;
  logic hit_std;
  logic hit_lia;
  logic hit_err;
  logic [15:0] std_clr;
  logic [15:0] lia_clr;
  logic [15:0] err_clr;

  assign overflow = in_queue_overflow_i | out_queue_overflow_i;

  assign std_if.set = {
    pon_pending_reg,
    evt_front_panel_i,
    evt_illegal_cmd_i,
    evt_exec_err_i,
    out_queue_overflow_i,
    1'b0,
    in_queue_overflow_i,
    evt_opc_i
  };

  assign lia_if.set = {
    sweep_done_i,
    sweep_started_i,
    capture_done_i,
    data_ch4_overload_i,
    data_ch3_overload_i,
    data_ch2_overload_i,
    data_ch1_overload_i,
    storage_triggered_i,
    sync_filter_overload_i,
    sync_freq_out_of_range_i,
    input_range_overload_i,
    reference_unlock_i,
    1'b0,
    out2_scale_overload_i,
    out1_scale_overload_i
  };

  assign err_if.set = {
    usb_host_fault_i,
    usb_device_fault_i,
    gpib_fast_abort_i,
    vxi_err_i,
    2'b00,
    battery_backup_fail_i,
    ext_ref_clock_err_i
  };

  // Query decode; the poll byte read clears nothing.
  assign hit_spoll = query_valid_i && (query_target_i == SER_Q_SPOLL);
  assign hit_std = query_valid_i && (query_target_i == SER_Q_STD);
  assign hit_lia = query_valid_i && (query_target_i == SER_Q_LOCKIN);
  assign hit_err = query_valid_i && (query_target_i == SER_Q_ERROR);
  assign std_clr = rd_mask(hit_std);
  assign lia_clr = rd_mask(hit_lia);
  assign err_clr = rd_mask(hit_err);

  assign std_if.rd_clr = std_clr[ESR_W-1:0];
  assign lia_if.rd_clr = lia_clr[LIA_W-1:0];
  assign err_if.rd_clr = err_clr[ERR_W-1:0];
  assign std_if.clr_all = clear_all_i;
  assign lia_if.clr_all = clear_all_i;
  assign err_if.clr_all = clear_all_i;
  assign std_if.enable = std_enable_i;
  assign lia_if.enable = lockin_enable_i;
  assign err_if.enable = error_enable_i;

  ser_sticky #(.W(ESR_W), .USED(ESR_USED), .RESET_VAL(ESR_RESET)) u_std (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .st(std_if.store)
  );

  ser_sticky #(.W(LIA_W), .USED(LIA_USED), .RESET_VAL(LIA_RESET)) u_lia (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .st(lia_if.store)
  );

  ser_sticky #(.W(ERR_W), .USED(ERR_USED), .RESET_VAL(ERR_RESET)) u_err (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .st(err_if.store)
  );

  // Poll byte conditions without the request bit.
  assign stb_cond = {
    2'b00,
    std_if.summary,
    out_buf_nonempty_i,
    lia_if.summary,
    err_if.summary,
    2'b00
  };
  assign spoll_en = stb_cond & spoll_enable_i;

  assign srq_if.cond = stb_cond;
  assign srq_if.enable = spoll_enable_i;
  assign srq_if.poll = serial_poll_i;

  ser_srq u_srq (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sq(srq_if.gen)
  );

  // Command read shows the enabled summary, not the request history.
  assign stb_read = stb_cond | ({7'h00, srq_if.mss} << STB_RQS_BIT);

  assign query_data_next = hit_spoll ? pick({8'h00, stb_read}) :
                           hit_std ? pick({8'h00, std_if.status}) :
                           hit_lia ? pick({1'b0, lia_if.status}) :
                           hit_err ? pick({8'h00, err_if.status}) :
                           query_data_reg;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pon_pending_reg <= 1'b1;
      queue_flush_reg <= 1'b0;
      query_data_reg <= LIA_RESET;
      query_done_reg <= 1'b0;
      spoll_byte_reg <= STB_RESET;
      spoll_done_reg <= 1'b0;
    end
    else
    begin
      pon_pending_reg <= 1'b0;
      queue_flush_reg <= overflow;
      query_data_reg <= query_data_next;
      query_done_reg <= query_valid_i;
      if (serial_poll_i)
        spoll_byte_reg <= stb_cond | ({7'h00, srq_if.pending} << STB_RQS_BIT);
      spoll_done_reg <= serial_poll_i;
    end
  end

  assign query_data_o = query_data_reg;
  assign query_done_o = query_done_reg;
  assign spoll_byte_o = spoll_byte_reg;
  assign spoll_done_o = spoll_done_reg;
  assign srq_o = srq_if.pending;
  assign queue_flush_o = queue_flush_reg;

  unlock_latch_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    reference_unlock_i |=> lia_if.status[LIA_REFERENCE_UNLOCK_BIT])
    else $error("unlock event not latched");

  err_summary_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (hit_spoll && !query_one_bit_i) |=>
      query_data_o[STB_ERR_BIT] == $past(|(err_if.status & error_enable_i)))
    else $error("error summary wrong in poll byte");

  mav_track_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (hit_spoll && !query_one_bit_i) |=> query_data_o[STB_MAV_BIT] == $past(out_buf_nonempty_i))
    else $error("buffer bit does not follow buffer state");

  esb_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (std_if.summary && !hit_std && !clear_all_i) |=> (std_if.summary || std_enable_i != $past(std_enable_i)))
    else $error("event summary dropped while enabled bits remain");

  stb_query_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (hit_spoll && !serial_poll_i && srq_o) |=> srq_o)
    else $error("command read of poll byte cleared the request");

  mss_read_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (hit_spoll && !query_one_bit_i) |=> query_data_o[STB_RQS_BIT] == $past(|spoll_en))
    else $error("command read bit 6 does not match enabled bits");

  poll_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (serial_poll_i && srq_o && spoll_en == $past(spoll_en)) |=>
      spoll_done_o && spoll_byte_o[STB_RQS_BIT] && !srq_o)
    else $error("poll did not report and clear the request");

  single_srq_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ($past(reset_n_i) && !srq_o && spoll_en == $past(spoll_en)) |=> !srq_o)
    else $error("request raised without a new enabled bit");

  rise_srq_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (|(spoll_en & ~$past(spoll_en))) |=> srq_o)
    else $error("rising enabled bit raised no request");

  read_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (hit_err && !query_one_bit_i && err_if.set == 8'h00) |=> err_if.status == ERR_RESET)
    else $error("whole read did not clear error byte");

  clear_all_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (clear_all_i && lia_if.set == LIA_RESET && std_if.set == ESR_RESET) |=>
      lia_if.status == LIA_RESET && std_if.status == ESR_RESET)
    else $error("clear-all left status bits set");

  flush_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    out_queue_overflow_i |=> queue_flush_o && std_if.status[ESR_QRY_BIT])
    else $error("output overflow did not flush and flag");

  pon_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    pon_pending_reg |=> std_if.status[ESR_PON_BIT] && !pon_pending_reg)
    else $error("power-on bit not set after reset");
endmodule // ser_top
`default_nettype wire

// [test/ser_host_model.sv]
// Behavioural remote controller that answers service requests with serial polls.
`default_nettype none
module ser_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic auto_i,
  input wire logic force_i,
  input wire logic [1:0] delay_i,
  input wire logic srq_i,
  input wire logic done_i,
  input wire logic [7:0] byte_i,
  output logic poll_o,
  output logic [7:0] byte_o,
  output logic [7:0] polls_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  logic want_q;
  // The poll pulse is launched delay_i cycles after a request is seen, so prompt and slow hosts both occur.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      poll_o <= 1'b0;
      wait_q <= 2'h0;
      want_q <= 1'b0;
    end
    else if (poll_o)
      poll_o <= 1'b0;
    else if ((auto_i && srq_i) || force_i || want_q)
    begin
      want_q <= (wait_q != delay_i);
      wait_q <= (wait_q == delay_i) ? 2'h0 : wait_q + 2'h1;
      poll_o <= (wait_q == delay_i);
    end
  end
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      byte_o <= 8'h00;
      polls_o <= 8'h00;
    end
    else if (done_i)
    begin
      byte_o <= byte_i;
      polls_o <= polls_o + 8'h01;
    end
  end
endmodule // ser_host_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the status event reporting block.
`default_nettype none
module tb_top import ser_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [25:0] evt = '0;
  logic obuf = 1'b0, clr = 1'b0, qv = 1'b0, q1 = 1'b0, frc = 1'b0, auto = 1'b0;
  ser_query_e qt = SER_Q_SPOLL;
  logic [3:0] qidx = 4'h0;
  logic [1:0] dly = 2'h0;
  logic [7:0] std_en = '0, err_en = '0, spe = '0, hbyte, polls, sp_byte;
  logic [14:0] lia_en = '0, qd;
  logic qdone, sp_done, srq, flush, sp_poll;
  logic [14:0] exp_r [3];
  int error_cnt = 0, checks_done = 0, cyc = 0;

  always #10 clk = ~clk;

  ser_top dut_u (.clk_sys_i(clk), .reset_n_i(rst_n),
    .evt_opc_i(evt[0]), .in_queue_overflow_i(evt[1]), .out_queue_overflow_i(evt[2]), .evt_exec_err_i(evt[3]),
    .evt_illegal_cmd_i(evt[4]), .evt_front_panel_i(evt[5]), .out1_scale_overload_i(evt[6]),
    .out2_scale_overload_i(evt[7]), .reference_unlock_i(evt[8]), .input_range_overload_i(evt[9]),
    .sync_freq_out_of_range_i(evt[10]), .sync_filter_overload_i(evt[11]), .storage_triggered_i(evt[12]),
    .data_ch1_overload_i(evt[13]), .data_ch2_overload_i(evt[14]), .data_ch3_overload_i(evt[15]),
    .data_ch4_overload_i(evt[16]), .capture_done_i(evt[17]), .sweep_started_i(evt[18]), .sweep_done_i(evt[19]),
    .ext_ref_clock_err_i(evt[20]), .battery_backup_fail_i(evt[21]), .vxi_err_i(evt[22]),
    .gpib_fast_abort_i(evt[23]), .usb_device_fault_i(evt[24]), .usb_host_fault_i(evt[25]),
    .out_buf_nonempty_i(obuf), .std_enable_i(std_en), .lockin_enable_i(lia_en), .error_enable_i(err_en),
    .spoll_enable_i(spe), .clear_all_i(clr), .query_valid_i(qv), .query_target_i(qt), .query_one_bit_i(q1),
    .query_bit_idx_i(qidx), .serial_poll_i(sp_poll), .query_data_o(qd), .query_done_o(qdone),
    .spoll_byte_o(sp_byte), .spoll_done_o(sp_done), .srq_o(srq), .queue_flush_o(flush));

  ser_host_model host_u (.clk_i(clk), .rst_n_i(rst_n), .auto_i(auto), .force_i(frc), .delay_i(dly),
    .srq_i(srq), .done_i(sp_done), .byte_i(sp_byte), .poll_o(sp_poll), .byte_o(hbyte), .polls_o(polls));

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk_q(input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    chk_q({7'h00, got}, {7'h00, exp});
  endtask

  // Bit position of event input i inside its status register.
  function automatic int pos_of(int i);
    if (i < 6)
      return (i < 2) ? i : i + 1;
    if (i < 20)
      return (i < 8) ? i - 6 : i - 5;
    return (i < 22) ? i - 20 : i - 18;
  endfunction

  function automatic logic [7:0] exp_stb();
    logic [7:0] b;
    b = 8'h00;
    b[STB_ERR_BIT] = |(exp_r[2][7:0] & err_en);
    b[STB_LIA_BIT] = |(exp_r[1] & lia_en);
    b[STB_ESB_BIT] = |(exp_r[0][7:0] & std_en);
    b[STB_MAV_BIT] = obuf;
    b[STB_RQS_BIT] = |(b & spe);
    return b;
  endfunction

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    exp_r = '{15'h0080, 15'h0000, 15'h0000};
  endtask

  task automatic fire(input logic [25:0] v);
    evt = v;
    @(negedge clk);
    evt = '0;
    for (int i = 0; i < 26; i++)
      if (v[i])
        exp_r[i < 6 ? 0 : (i < 20 ? 1 : 2)][pos_of(i)] = 1'b1;
  endtask

  // Target k: 0 poll byte, 1 event byte, 2 lock-in word, 3 error byte.
  task automatic read_reg(input int k, input logic one, input logic [3:0] idx);
    logic [14:0] e;
    int w;
    w = (k == 2) ? 15 : 8;
    e = (k == 0) ? {7'h00, exp_stb()} : exp_r[k-1];
    if (one)
      e = (idx < w) ? {14'h0000, e[idx]} : 15'h0000;
    qt = ser_query_e'(4'h1 << k);
    q1 = one;
    qidx = idx;
    qv = 1'b1;
    @(negedge clk);
    qv = 1'b0;
    for (int n = 0; n < 4 && qdone !== 1'b1; n++)
      @(negedge clk);
    chk_q(qd, e);
    chk_b(8'(qdone), 8'h01);
    if (k > 0 && (!one || idx < w))
      exp_r[k-1] = one ? exp_r[k-1] & ~(15'h0001 << idx) : 15'h0000;
  endtask

  task automatic wait_poll(input logic rq);
    logic [7:0] e;
    logic [7:0] p;
    p = polls;
    for (int n = 0; n < 12 && polls === p; n++)
      @(negedge clk);
    e = exp_stb();
    e[STB_RQS_BIT] = rq;
    chk_b(hbyte, e);
    chk_b(8'(srq), 8'h00);
  endtask

  initial
  begin
    void'($urandom(51));
    do_reset();
    read_reg(1, 1'b0, 4'h0);
    read_reg(1, 1'b0, 4'h0);
    for (int i = 0; i < 26; i++)
    begin
      fire(26'h1 << i);
      chk_b(flush, 8'(i == 1 || i == 2));
      read_reg(i < 6 ? 1 : (i < 20 ? 2 : 3), 1'b1, 4'(pos_of(i)));
      read_reg(i < 6 ? 1 : (i < 20 ? 2 : 3), 1'b0, 4'h0);
    end
    lia_en = 15'h0108;
    spe = 8'h08;
    auto = 1'b1;
    dly = 2'h2;
    fire(26'h1 << 8);
    wait_poll(1'b1);
    auto = 1'b0;
    fire(26'h1 << 13);
    repeat (3) @(negedge clk);
    chk_b(8'(srq), 8'h00);
    frc = 1'b1;
    @(negedge clk);
    frc = 1'b0;
    wait_poll(1'b0);
    read_reg(0, 1'b0, 4'h0);
    lia_en = 15'h0000;
    read_reg(0, 1'b0, 4'h0);
    read_reg(2, 1'b0, 4'h0);
    lia_en = 15'h0108;
    auto = 1'b1;
    dly = 2'h0;
    fire(26'h1 << 8);
    wait_poll(1'b1);
    for (int n = 0; n < 60; n++)
    begin
      std_en = 8'($urandom);
      lia_en = 15'($urandom);
      err_en = 8'($urandom);
      spe = 8'($urandom);
      obuf = 1'($urandom);
      dly = 2'($urandom);
      fire(26'($urandom & $urandom));
      read_reg(0, 1'($urandom), 4'($urandom));
      if ($urandom_range(3) == 0)
      begin
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        exp_r = '{default: '0};
        read_reg(0, 1'b0, 4'h0);
      end
      read_reg($urandom_range(3), 1'($urandom), 4'($urandom));
    end
    do_reset();
    read_reg(1, 1'b0, 4'h0);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
